// ### src/colour_stage_defs.vh
`ifndef COLOUR_STAGE_DEFS_VH
`define COLOUR_STAGE_DEFS_VH

// Register byte addresses
`define OFS_PATTERN        12'h000
`define OFS_BLACK0         12'h004
`define OFS_BLACK1         12'h008
`define OFS_MEDIAN         12'h00c
`define OFS_GAIN_R         12'h010
`define OFS_GAIN_GR        12'h014
`define OFS_GAIN_GB        12'h018
`define OFS_GAIN_B         12'h01c
`define OFS_CONTROL        12'h020
`define OFS_STATUS         12'h024

// Pattern map field positions (low bit of each two-bit field)
`define POS_F1P0           14
`define POS_F1P1           12
`define POS_F1P2           10
`define POS_F1P3           8
`define POS_F0P0           6
`define POS_F0P1           4
`define POS_F0P2           2
`define POS_F0P3           0

// Colour classes
`define CLS_R              2'd0
`define CLS_GR             2'd1
`define CLS_GB             2'd2
`define CLS_B              2'd3

// Field widths
`define PIX_W              14
`define GAIN_W             11
`define GAIN_FRAC          8
`define MEDIAN_W           14

// Reset values
`define RST_PATTERN        16'h0000
`define RST_BLACK          16'h0000
`define RST_MEDIAN         14'h0000
`define RST_GAIN           11'h100
`define RST_CONTROL        1'b0

// FIFO
`define FIFO_DEPTH         4
`define FIFO_AW            2

`endif

// ### src/pixel_fifo.v
`timescale 1ns/1ps
`default_nettype none

module pixel_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_q;
    reg  [AW-1:0]    rd_q;
    reg  [AW:0]      cnt_q;
    wire             push;
    wire             pop;
    localparam [AW:0] FULL_COUNT = DEPTH;

    assign in_ready  = (cnt_q != FULL_COUNT);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers wrap naturally only for power-of-two depth
    always @(posedge clk) begin
        if (rst) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // pixel_fifo

`default_nettype wire

// ### src/colour_stage.v
`timescale 1ns/1ps
`default_nettype none
`include "colour_stage_defs.vh"

module colour_stage (
    input  wire        SYS_CLK,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    input  wire        VERTICAL_SYNC_PULSE,
    input  wire        FIELD_ID,
    input  wire        LINE_START,
    input  wire        PIX_VALID,
    output wire        PIX_READY,
    input  wire [13:0] PIX_DATA,
    output wire        OUT_VALID,
    input  wire        OUT_READY,
    output wire [13:0] OUT_DATA,
    output wire [1:0]  OUT_CLASS,
    output wire [13:0] MEDIAN_THRESHOLD_VALUE
);
    // Software copies
    reg  [15:0] color_pattern_map_q;
    reg  [15:0] black_comp_red_greenred_q;
    reg  [15:0] black_comp_greenblue_blue_q;
    reg  [13:0] median_threshold_value_q;
    reg  [10:0] gain_red_class_q;
    reg  [10:0] gain_greenred_class_q;
    reg  [10:0] gain_greenblue_class_q;
    reg  [10:0] gain_blue_class_q;
    reg         stripe_mode_q;
    // Active copies, loaded at vertical sync
    reg  [15:0] act_pattern_q;
    reg  [7:0]  act_black_q [0:3];
    reg  [10:0] act_gain_q  [0:3];
    reg         act_stripe_q;
    reg  [15:0] vsync_count_q;
    // Pixel position tracking
    reg         line_odd_q;
    reg  [1:0]  pix_count_q;
    reg         first_line_q;

    wire        wr_en;
    wire        rd_en;
    wire        access;
    reg         addr_ok;

    assign access  = PSEL && PENABLE;
    assign PREADY  = 1'b1;
    assign wr_en   = access && PWRITE && addr_ok;
    // Read data latched in setup so it stands through the access phase
    assign rd_en   = PSEL && !PENABLE && !PWRITE;
    assign PSLVERR = access && !addr_ok;
    assign MEDIAN_THRESHOLD_VALUE = median_threshold_value_q;

    always @* begin
        case (PADDR)
            `OFS_PATTERN, `OFS_BLACK0, `OFS_BLACK1, `OFS_MEDIAN,
            `OFS_GAIN_R, `OFS_GAIN_GR, `OFS_GAIN_GB, `OFS_GAIN_B,
            `OFS_CONTROL, `OFS_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Register writes; reserved bits are dropped so they read zero
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            color_pattern_map_q         <= `RST_PATTERN;
            black_comp_red_greenred_q   <= `RST_BLACK;
            black_comp_greenblue_blue_q <= `RST_BLACK;
            median_threshold_value_q    <= `RST_MEDIAN;
            gain_red_class_q            <= `RST_GAIN;
            gain_greenred_class_q       <= `RST_GAIN;
            gain_greenblue_class_q      <= `RST_GAIN;
            gain_blue_class_q           <= `RST_GAIN;
            stripe_mode_q               <= `RST_CONTROL;
        end else if (wr_en) begin
            case (PADDR)
                `OFS_PATTERN: color_pattern_map_q <= PWDATA[15:0];
                `OFS_BLACK0:  black_comp_red_greenred_q <= PWDATA[15:0];
                `OFS_BLACK1:  black_comp_greenblue_blue_q <= PWDATA[15:0];
                `OFS_MEDIAN:  median_threshold_value_q <= PWDATA[13:0];
                `OFS_GAIN_R:  gain_red_class_q <= PWDATA[10:0];
                `OFS_GAIN_GR: gain_greenred_class_q <= PWDATA[10:0];
                `OFS_GAIN_GB: gain_greenblue_class_q <= PWDATA[10:0];
                `OFS_GAIN_B:  gain_blue_class_q <= PWDATA[10:0];
                `OFS_CONTROL: stripe_mode_q <= PWDATA[0];
                default: ;
            endcase
        end
    end

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_en) begin
            case (PADDR)
                `OFS_PATTERN: PRDATA <= {16'h0000, color_pattern_map_q};
                `OFS_BLACK0:  PRDATA <= {16'h0000, black_comp_red_greenred_q};
                `OFS_BLACK1:  PRDATA <= {16'h0000, black_comp_greenblue_blue_q};
                `OFS_MEDIAN:  PRDATA <= {18'h00000, median_threshold_value_q};
                `OFS_GAIN_R:  PRDATA <= {21'h000000, gain_red_class_q};
                `OFS_GAIN_GR: PRDATA <= {21'h000000, gain_greenred_class_q};
                `OFS_GAIN_GB: PRDATA <= {21'h000000, gain_greenblue_class_q};
                `OFS_GAIN_B:  PRDATA <= {21'h000000, gain_blue_class_q};
                `OFS_CONTROL: PRDATA <= {31'h00000000, stripe_mode_q};
                `OFS_STATUS:  PRDATA <= {act_stripe_q, 15'h0000, vsync_count_q};
                default:      PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Shadow transfer; mid-frame writes, except to the median threshold, never tear a frame
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            act_pattern_q  <= `RST_PATTERN;
            act_stripe_q   <= `RST_CONTROL;
            act_black_q[0] <= 8'h00;
            act_black_q[1] <= 8'h00;
            act_black_q[2] <= 8'h00;
            act_black_q[3] <= 8'h00;
            act_gain_q[0]  <= `RST_GAIN;
            act_gain_q[1]  <= `RST_GAIN;
            act_gain_q[2]  <= `RST_GAIN;
            act_gain_q[3]  <= `RST_GAIN;
            vsync_count_q  <= 16'h0000;
        end else if (VERTICAL_SYNC_PULSE) begin
            act_pattern_q  <= color_pattern_map_q;
            act_stripe_q   <= stripe_mode_q;
            act_black_q[0] <= black_comp_red_greenred_q[15:8];
            act_black_q[1] <= black_comp_red_greenred_q[7:0];
            act_black_q[2] <= black_comp_greenblue_blue_q[15:8];
            act_black_q[3] <= black_comp_greenblue_blue_q[7:0];
            act_gain_q[0]  <= gain_red_class_q;
            act_gain_q[1]  <= gain_greenred_class_q;
            act_gain_q[2]  <= gain_greenblue_class_q;
            act_gain_q[3]  <= gain_blue_class_q;
            vsync_count_q  <= vsync_count_q + 16'h0001;
        end
    end

    // Line parity and pixel count; first line after vsync is even
    wire pix_take;
    wire fifo_in_ready;
    reg  stage_valid_q;
    assign pix_take  = PIX_VALID && PIX_READY;

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            line_odd_q   <= 1'b0;
            pix_count_q  <= 2'd0;
            first_line_q <= 1'b1;
        end else if (VERTICAL_SYNC_PULSE) begin
            line_odd_q   <= 1'b0;
            pix_count_q  <= 2'd0;
            first_line_q <= 1'b1;
        end else if (LINE_START) begin
            line_odd_q   <= first_line_q ? 1'b0 : ~line_odd_q;
            pix_count_q  <= 2'd0;
            first_line_q <= 1'b0;
        end else if (pix_take) begin
            if (act_stripe_q) begin
                pix_count_q <= (pix_count_q == 2'd2) ? 2'd0 : pix_count_q + 2'd1;
            end else begin
                pix_count_q <= {1'b0, ~pix_count_q[0]};
            end
        end
    end

    // Position index 0..3 into the chosen field's byte
    reg  [1:0] pos;
    reg  [1:0] cls;
    wire [7:0] field_map;
    assign field_map = FIELD_ID ? act_pattern_q[15:8] : act_pattern_q[7:0];

    always @* begin
        if (act_stripe_q) begin
            pos = pix_count_q;
        end else begin
            pos = {line_odd_q, pix_count_q[0]};
        end
        case (pos)
            2'd0: cls = field_map[7:6];
            2'd1: cls = field_map[5:4];
            2'd2: cls = field_map[3:2];
            2'd3: cls = field_map[1:0];
            default: cls = `CLS_R;
        endcase
    end

    // Black compensation then gain, both with saturation
    wire signed [15:0] comp_sum;
    wire        [14:0] comp_pix;
    wire        [25:0] product;
    wire        [17:0] gained;
    reg         [13:0] result;
    assign comp_sum = $signed({2'b00, PIX_DATA})
                    + $signed({{8{act_black_q[cls][7]}}, act_black_q[cls]});
    assign comp_pix = comp_sum[15] ? 15'h0000 : comp_sum[14:0];
    assign product  = comp_pix * act_gain_q[cls];
    assign gained   = product[25:8];

    always @* begin
        if (gained > 18'h03fff) begin
            result = 14'h3fff;
        end else begin
            result = gained[13:0];
        end
    end

    // One output register stage, stalled by the FIFO
    reg  [13:0] stage_data_q;
    reg  [1:0]  stage_class_q;
    wire [15:0] fifo_out;
    assign PIX_READY = !stage_valid_q || fifo_in_ready;

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            stage_valid_q <= 1'b0;
            stage_data_q  <= 14'h0000;
            stage_class_q <= `CLS_R;
        end else if (PIX_READY) begin
            stage_valid_q <= PIX_VALID;
            if (PIX_VALID) begin
                stage_data_q  <= result;
                stage_class_q <= cls;
            end
        end
    end

    pixel_fifo #(
        .WIDTH (16),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst       (RESET),
        .in_valid  (stage_valid_q),
        .in_ready  (fifo_in_ready),
        .in_data   ({stage_class_q, stage_data_q}),
        .out_valid (OUT_VALID),
        .out_ready (OUT_READY),
        .out_data  (fifo_out)
    );

    assign OUT_DATA  = fifo_out[13:0];
    assign OUT_CLASS = fifo_out[15:14];
endmodule // colour_stage

`default_nettype wire

// ### dv/colour_stage_checker.sv
`timescale 1ns/1ps
`default_nettype none
module colour_stage_checker (
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PSLVERR,
    input wire logic        PIX_VALID,
    input wire logic        PIX_READY,
    input wire logic        OUT_VALID,
    input wire logic        OUT_READY,
    input wire logic [13:0] OUT_DATA,
    input wire logic [1:0]  OUT_CLASS,
    input wire logic [13:0] MEDIAN_THRESHOLD_VALUE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    sequence s_rd; PSEL && PENABLE && !PWRITE; endsequence
    sequence s_take; PIX_VALID && PIX_READY; endsequence
    property p_med;
        PSEL && PENABLE && PWRITE && PADDR == 12'h00c
        |=> {18'h0, MEDIAN_THRESHOLD_VALUE} == ($past(PWDATA) & 32'h3fff);
    endproperty
    property p_medrd; s_rd ##0 (PADDR == 12'h00c) |-> PRDATA[31:14] == 18'h0; endproperty
    property p_gainrd; s_rd ##0 (PADDR[11:4] == 8'h01) |-> PRDATA[31:11] == 21'h0; endproperty
    property p_blkrd; s_rd ##0 (PADDR < 12'h00c) |-> PRDATA[31:16] == 16'h0; endproperty
    property p_unmap; s_rd ##0 (PADDR > 12'h024) |-> PSLVERR && PRDATA == 32'h0; endproperty
    property p_hold;
        OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_CLASS);
    endproperty
    property p_lat; s_take |-> ##[1:2] OUT_VALID; endproperty
    property p_full; !PIX_READY |-> OUT_VALID; endproperty
    a_med: assert property (p_med) else $error("median port");
    a_medrd: assert property (p_medrd) else $error("median upper");
    a_gainrd: assert property (p_gainrd) else $error("gain upper");
    a_blkrd: assert property (p_blkrd) else $error("black upper");
    a_unmap: assert property (p_unmap) else $error("unmapped");
    a_hold: assert property (p_hold) else $error("out hold");
    a_lat: assert property (p_lat) else $error("latency");
    a_full: assert property (p_full) else $error("refuse");
endmodule // colour_stage_checker
bind colour_stage colour_stage_checker u_chk (.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PSLVERR, .PIX_VALID, .PIX_READY, .OUT_VALID, .OUT_READY,
    .OUT_DATA, .OUT_CLASS, .MEDIAN_THRESHOLD_VALUE);
`default_nettype wire

// ### dv/pixel_source.sv
`timescale 1ns/1ps
`default_nettype none
module pixel_source (
    input  wire logic        SYS_CLK,
    input  wire logic        PIX_READY,
    output var  logic        PIX_VALID,
    output var  logic [13:0] PIX_DATA
);
    initial begin
        PIX_VALID = 1'b0;
        PIX_DATA = 14'h0;
    end
    // Inverse after take so stale data never looks valid
    task automatic send(input logic [13:0] d, output logic ok);
        int n;
        PIX_VALID <= 1'b1;
        PIX_DATA <= d;
        ok = 1'b0;
        for (n = 0; n < 300 && !ok; n++) begin
            @(posedge SYS_CLK);
            ok = (PIX_READY === 1'b1);
        end
        PIX_VALID <= 1'b0;
        PIX_DATA <= ~d;
    endtask
endmodule // pixel_source
`default_nettype wire

// ### dv/tb_colour_stage.sv
`timescale 1ns/1ps
`default_nettype none
module tb_colour_stage;
    logic        SYS_CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic        VERTICAL_SYNC_PULSE = 0, FIELD_ID = 0, LINE_START = 0, OUT_READY = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA;
    logic        PREADY, PSLVERR, PIX_VALID, PIX_READY, OUT_VALID, strp, odd, hold;
    logic [13:0] PIX_DATA, OUT_DATA, MEDIAN_THRESHOLD_VALUE;
    logic [1:0]  OUT_CLASS;
    logic [15:0] exp_q[$], pat, e;
    logic [31:0] wr[8];
    logic [7:0]  blk[4];
    logic [10:0] gn[4];
    int          bad_count = 0, n_compared = 0, cnt;
    always #4 SYS_CLK = ~SYS_CLK;
    colour_stage dut (.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .VERTICAL_SYNC_PULSE, .FIELD_ID, .LINE_START, .PIX_VALID,
        .PIX_READY, .PIX_DATA, .OUT_VALID, .OUT_READY, .OUT_DATA, .OUT_CLASS,
        .MEDIAN_THRESHOLD_VALUE);
    pixel_source src (.SYS_CLK, .PIX_READY, .PIX_VALID, .PIX_DATA);
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        n_compared++;
        if (s !== x) begin
            $display("ERROR %s expected %h seen %h", nm, x, s);
            bad_count++;
        end
    endtask
    task automatic tmo(input string nm);
        chk(nm, 32'h1, 32'h0);
        report_and_stop();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic er);
        int n;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge SYS_CLK);
            if (PREADY === 1'b1) break;
        end
        if (n == 50) tmo("apb wait");
        er = PSLVERR;
        r = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // Idle edge so the next call never re-drives PSEL in this step
        @(posedge SYS_CLK);
    endtask
    function automatic logic [15:0] expect_pix(input logic [13:0] p);
        logic [7:0] fb;
        logic [1:0] ps, c;
        int v;
        fb = FIELD_ID ? pat[15:8] : pat[7:0];
        ps = strp ? 2'(cnt) : {odd, cnt[0]};
        c = fb[7 - 2 * ps -: 2];
        cnt = strp ? (cnt + 1) % 3 : cnt ^ 1;
        v = int'(p) + int'($signed(blk[c]));
        if (v < 0) v = 0;
        v = (v * int'(gn[c])) >>> 8;
        if (v > 16383) v = 16383;
        return {c, v[13:0]};
    endfunction
    task automatic pix;
        logic ok;
        logic [13:0] p;
        int k;
        k = $urandom % 4;
        p = k == 0 ? 14'h0 : k == 1 ? 14'h3fff : 14'($urandom);
        exp_q.push_back(expect_pix(p));
        src.send(p, ok);
        if (!ok) tmo("pixel take");
        repeat ($urandom_range(1, 3)) @(posedge SYS_CLK);
    endtask
    task automatic line(input int n);
        LINE_START <= 1'b1;
        @(posedge SYS_CLK);
        LINE_START <= 1'b0;
        odd = ~odd;
        cnt = 0;
        repeat (n) pix();
    endtask
    always @(posedge SYS_CLK) begin
        if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
            chk("out_data", 32'(e[13:0]), 32'(OUT_DATA));
            chk("out_class", 32'(e[15:14]), 32'(OUT_CLASS));
        end
        OUT_READY <= !hold && ($urandom % 4 != 0);
    end
    initial begin
        logic [31:0] r;
        logic er;
        int f, i;
        void'($urandom(55));
        pat = 0;
        blk = '{default: 8'h0};
        gn = '{default: 11'h100};
        {strp, odd, hold, cnt} = {3'b010, 32'd0};
        repeat (12) @(posedge SYS_CLK);
        RESET <= 1'b0;
        @(posedge SYS_CLK);
        for (i = 0; i < 11; i++) begin
            apb(0, 12'(4 * i), 0, r, er);
            chk("reset_val", (i >= 4 && i < 8) ? 32'h100 : 32'h0, r);
            chk("slverr", 32'(i == 10), 32'(er));
        end
        for (f = 0; f < 4; f++) begin
            foreach (wr[i]) wr[i] = $urandom;
            if (f == 3) {wr[1], wr[4]} = {32'h807f, 32'h7ff};
            foreach (wr[i]) apb(1, 12'(4 * i), wr[i], r, er);
            apb(1, 12'h020, 32'(f >> 1), r, er);
            apb(1, 12'h028, 32'hffffffff, r, er);
            foreach (wr[i]) begin
                apb(0, 12'(4 * i), 0, r, er);
                chk("reg", wr[i] & (i == 3 ? 32'h3fff : i > 3 ? 32'h7ff : 32'hffff), r);
            end
            apb(0, 12'h028, 0, r, er);
            chk("unmapped", 32'h0, r);
            chk("median_port", wr[3] & 32'h3fff, 32'(MEDIAN_THRESHOLD_VALUE));
            repeat (3) pix();
            VERTICAL_SYNC_PULSE <= 1'b1;
            FIELD_ID <= f[0];
            @(posedge SYS_CLK);
            VERTICAL_SYNC_PULSE <= 1'b0;
            {pat, blk[0], blk[1], blk[2], blk[3]} = {wr[0][15:0], wr[1][15:0], wr[2][15:0]};
            foreach (gn[i]) gn[i] = wr[4 + i][10:0];
            {strp, odd} = {f[1], 1'b1};
            apb(0, 12'h024, 0, r, er);
            chk("status", {f[1], 15'h0000, 16'(f + 1)}, r);
            if (f == 1) begin
                hold <= 1'b1;
                fork
                    line(9);
                join_none
                for (i = 0; i < 200 && PIX_READY !== 1'b0; i++) @(posedge SYS_CLK);
                chk("refuse", 32'h0, 32'(PIX_READY));
                hold <= 1'b0;
                wait fork;
            end else begin
                line(6);
            end
            line(6);
        end
        for (i = 0; i < 500 && exp_q.size() > 0; i++) @(posedge SYS_CLK);
        if (exp_q.size() > 0) tmo("drain");
        report_and_stop();
    end
endmodule // tb_colour_stage
`default_nettype wire
